// ===== bench/radio_state_transition_config_bench.sv
// Self-checking bench for the radio state transition block, with an event-level model.
// Assumes the hw files are compiled first; the bench drives every input itself.
`include "radio_regs.svh"
`default_nettype none

module radio_state_transition_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CAL = 2;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic clk_en = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic rssi_below_threshold = 1'h0, packet_receiving = 1'h0;
    logic [6:0] ev = 7'h00;
    wire logic enter_rx_strobe = ev[0], enter_tx_strobe = ev[1], synth_on_tx_ready_strobe = ev[2];
    wire logic enter_idle_strobe = ev[3], manual_calibrate_strobe = ev[4], rx_packet_done = ev[5];
    wire logic tx_packet_done = ev[6];
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic clear_channel, calibrating, preamble_restart;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [2:0] radio_state;
    int fails = 0, num_checks = 0, cycles = 0, st = 0, cnt = 0;
    logic [5:0] tc = 6'h30;
    logic [1:0] ac = 2'h0;
    logic ccm = 1'h0;
    int seq[8] = '{0, 5, 3, 2, 1, 6, 3, 4};

    radio_state_transition_config #(.CAL_CYCLES(CAL)) radio_state_transition_config_i (.*);

    always #12.5ns aclk = ~aclk;

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            $display("ERROR at %0t: run limit reached", $time);
            tally_and_finish();
        end
    end

    task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Readies and answers are sampled at the falling edge; inputs only move after rising edges
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ah, wh, bh;
        logic [1:0] r;
        n = 0;
        bh = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!bh && n < 50)
        begin
            @(negedge aclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'h0;
            if (wh) s_axi_wvalid <= 1'h0;
            // Late ready makes the response wait
            if (n == 2) s_axi_bready <= 1'h1;
            n++;
        end
        s_axi_bready <= 1'h0;
        check({bh, r}, {1'h1, er}, "write response");
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        logic ah, rh;
        logic [33:0] got;
        n = 0;
        rh = 1'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        while (!rh && n < 50)
        begin
            @(negedge aclk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid && s_axi_rready;
            got = {s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'h0;
            if (n == 1) s_axi_rready <= 1'h1;
            n++;
        end
        s_axi_rready <= 1'h0;
        check({rh, got}, {1'h1, er, exp}, "read");
    endtask : axi_read

    task automatic set_cfg(input logic [5:0] t, input logic [1:0] a);
        if (t[3:2] == 2'h1 || t[3:2] == 2'h2) t[5:4] = 2'h0;
        tc = t;
        ac = a;
        axi_write(`TRANS_CTRL_ADDR, {26'($urandom), t}, `RESP_OKAY);
        axi_write(`CAL_CTRL_ADDR, {26'h0, a, 4'h0}, `RESP_OKAY);
    endtask : set_cfg

    task automatic fire(input int b);
        int nx, n;
        logic calx, prex, r, p;
        nx = st;
        calx = st == 0 && b == 4;
        if (st == 0 && b < 3)
        begin
            nx = b + 1;
            calx = ac == 2'h1;
        end
        if (st == 1 && b == 5) nx = tc[3:2] == 2'h1 ? 3 : tc[3:2] == 2'h3 ? 1 : tc[3:2];
        if (st == 2 && b == 6) nx = tc[1:0] == 2'h2 ? 3 : tc[1:0] == 2'h3 ? 2 : tc[1:0];
        if (st == 3 && b == 1) nx = 2;
        if (st != 0 && b == 3) nx = 0;
        prex = st == 2 && b == 6 && tc[1:0] == 2'h3;
        if ((st == 1 || st == 2) && nx == 0)
        begin
            calx = ac == 2'h2 || (ac == 2'h3 && cnt == 3);
            cnt = (cnt + 1) % 4;
        end
        r = 1'($urandom);
        p = 1'($urandom);
        ccm = tc[5:4] == 2'h0 ? 1'h1 : tc[5:4] == 2'h1 ? r : tc[5:4] == 2'h2 ? !p : r && !p;
        @(posedge aclk);
        ev <= 7'h01 << b;
        rssi_below_threshold <= r;
        packet_receiving <= p;
        if ($urandom_range(0, 3) == 0)
        begin
            // Frozen edge must not take the strobe
            clk_en <= 1'h0;
            @(posedge aclk);
            clk_en <= 1'h1;
        end
        @(posedge aclk);
        ev <= 7'h00;
        #1;
        check(clear_channel, ccm, "clear channel");
        check(preamble_restart, prex, "preamble restart");
        check(calibrating, calx, "calibration start");
        n = 0;
        while (calibrating === 1'h1 && n < 100)
        begin
            @(posedge aclk);
            #1;
            n++;
        end
        if (calx) check(n, CAL, "calibration length");
        check(radio_state, nx, "next state");
        st = nx;
    endtask : fire

    initial
    begin
        int s;
        s = $urandom(32'hEACA6A96);
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        axi_read(`TRANS_CTRL_ADDR, 32'h30, `RESP_OKAY);
        axi_read(`CAL_CTRL_ADDR, 32'h0, `RESP_OKAY);
        axi_write(`TRANS_CTRL_ADDR, 32'hFFFFFFFF, `RESP_OKAY);
        axi_read(`TRANS_CTRL_ADDR, 32'h3F, `RESP_OKAY);
        axi_write(`CAL_CTRL_ADDR, 32'hFFFFFFFF, `RESP_OKAY);
        axi_read(`CAL_CTRL_ADDR, 32'h30, `RESP_OKAY);
        axi_write(8'h10, 32'h1, `RESP_SLVERR);
        axi_read(8'h10, 32'h0, `RESP_SLVERR);
        $display("Test registers done");
        // Every after-receive, after-transmit and calibration code, ending with code 3
        for (int i = 0; i < 64; i++)
        begin
            set_cfg({2'($urandom), 4'(i)}, 2'(i >> 4));
            foreach (seq[k]) fire(seq[k]);
        end
        $display("Test mode sweep done");
        for (int i = 0; i < 300; i++)
        begin
            if ($urandom_range(0, 7) == 0) set_cfg(6'($urandom), 2'($urandom));
            fire($urandom_range(0, 6));
            if (i % 16 == 0) axi_read(`STATUS_ADDR, {26'h0, 2'(cnt), ccm, 3'(st)}, `RESP_OKAY);
        end
        $display("Test random traffic done");
        tally_and_finish();
    end
endmodule : radio_state_transition_config_bench

`default_nettype wire

// ===== bench/radio_transition_assertions.sv
// Concurrent checks on the top-level ports of the radio state transition block.
// Assumes clk_en stays high while calibrating; bound into every instance of the top.
`include "radio_regs.svh"
`default_nettype none

module radio_transition_checker #(
    parameter int CAL_CYCLES = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rssi_below_threshold,
    input wire logic packet_receiving,
    input wire logic tx_packet_done,
    input wire logic enter_rx_strobe,
    input wire logic manual_calibrate_strobe,
    input wire logic clear_channel,
    input wire logic [2:0] radio_state,
    input wire logic calibrating,
    input wire logic preamble_restart
);
    logic [15:0] cal_cnt_reg;
    logic [15:0] cal_cnt_next;

    // Counts cycles spent calibrating; too long to unroll as a repetition
    always_comb cal_cnt_next = (!aresetn || !calibrating) ? 16'h0 : cal_cnt_reg + 16'h1;
    always_ff @(posedge aclk) cal_cnt_reg <= cal_cnt_next;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed early");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed early");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_cal_length: assert property ($fell(calibrating) |-> cal_cnt_reg == CAL_CYCLES)
        else $error("calibration length wrong");
    chk_cal_bound: assert property (calibrating |-> cal_cnt_reg < CAL_CYCLES)
        else $error("calibration overran");
    chk_clear_case: assert property ($past(aresetn) && $past(clk_en) && $past(rssi_below_threshold)
        && !$past(packet_receiving) |-> clear_channel)
        else $error("channel not reported clear");
    chk_preamble_tx: assert property (preamble_restart |-> $past(tx_packet_done) && radio_state == `ST_CODE_TX)
        else $error("preamble restart outside transmit");
    chk_manual_cal: assert property (radio_state == `ST_CODE_IDLE && manual_calibrate_strobe && clk_en
        |=> calibrating)
        else $error("manual calibration not started");
    chk_rx_entry: assert property (radio_state == `ST_CODE_IDLE && enter_rx_strobe && !manual_calibrate_strobe
        && clk_en |=> radio_state == `ST_CODE_RX || calibrating)
        else $error("receive entry missed");
endmodule : radio_transition_checker

bind radio_state_transition_config radio_transition_checker #(.CAL_CYCLES(CAL_CYCLES)) radio_transition_checker_i (.*);

`default_nettype wire

// ===== hw/axil_reg_port.sv
// AXI4-Lite slave front end: turns bus writes into single-cycle register strobes.
// Assumes a register file on the same clock answering reads combinationally.
`include "radio_regs.svh"
`default_nettype none

module axil_reg_port
    import radio_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    reg_port_if.port rp
);

    logic aw_held_reg, aw_held_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic w_held_reg, w_held_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic do_wr;

    // Readies drop with the clock enable so no transfer is lost while frozen
    assign s_axi_awready = clk_en && !aw_held_reg;
    assign s_axi_wready = clk_en && !w_held_reg;
    assign s_axi_arready = clk_en && !rvalid_reg;
    assign do_wr = clk_en && aw_held_reg && w_held_reg && !bvalid_reg;

    assign rp.wr_en = do_wr;
    assign rp.wr_addr = aw_addr_reg;
    assign rp.wr_data = w_data_reg;
    assign rp.wr_strb = w_strb_reg;
    assign rp.rd_addr = s_axi_araddr;

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_comb
    begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (do_wr)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = rp.wr_err ? `RESP_SLVERR : `RESP_OKAY;
        end
        else if (bvalid_reg && s_axi_bready && clk_en)
        begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rdata_next = rp.rd_data;
            rresp_next = rp.rd_err ? `RESP_SLVERR : `RESP_OKAY;
        end
        else if (rvalid_reg && s_axi_rready && clk_en)
        begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `RESP_OKAY;
        end
        else if (clk_en)
        begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

endmodule : axil_reg_port

`default_nettype wire

// ===== hw/radio_pkg.sv
// Types shared by the radio state transition block.
// Assumes radio_regs.svh supplies the numeric codes.
`default_nettype none

package radio_pkg;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_TX, ST_SYNTH_ON, ST_CAL} radio_state_e;
    typedef logic [1:0] field_t;

endpackage : radio_pkg

`default_nettype wire

// ===== hw/radio_regs.svh
// Register map, field positions, codes and reset values of the radio state transition block.
// Assumes 32-bit AXI4-Lite access, one register per aligned word.
`ifndef RADIO_REGS_SVH
`define RADIO_REGS_SVH

// Printed index kept; byte address is four times the index
`define TRANS_CTRL_IDX 8'h17
`define TRANS_CTRL_ADDR 8'h5C
`define CAL_CTRL_IDX 8'h20
`define CAL_CTRL_ADDR 8'h80
`define STATUS_IDX 8'h21
`define STATUS_ADDR 8'h84

`define CCA_SEL_LSB 4
`define RXOFF_LSB 2
`define TXOFF_LSB 0
`define AUTOCAL_LSB 4
`define STAT_STATE_LSB 0
`define STAT_CCA_BIT 3
`define STAT_IDLECNT_LSB 4

`define TRANS_CTRL_RESET 6'h30
`define CAL_CTRL_RESET 2'h0

`define CCA_ALWAYS 2'h0
`define CCA_RSSI 2'h1
`define CCA_NOT_RX 2'h2
`define CCA_RSSI_NOT_RX 2'h3

`define RXOFF_IDLE 2'h0
`define RXOFF_SYNTH_ON 2'h1
`define RXOFF_TX 2'h2
`define RXOFF_STAY 2'h3

`define TXOFF_IDLE 2'h0
`define TXOFF_RX 2'h1
`define TXOFF_SYNTH_ON 2'h2
`define TXOFF_STAY 2'h3

`define AUTOCAL_NEVER 2'h0
`define AUTOCAL_FROM_IDLE 2'h1
`define AUTOCAL_TO_IDLE 2'h2
`define AUTOCAL_FOURTH 2'h3
`define IDLE_COUNT_LAST 2'h3

`define ST_CODE_IDLE 3'h0
`define ST_CODE_RX 3'h1
`define ST_CODE_TX 3'h2
`define ST_CODE_SYNTH_ON 3'h3
`define ST_CODE_CAL 3'h4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== hw/radio_state_transition_config.sv
// Radio main control state machine with its transition and calibration settings.
// Assumes radio status inputs and command strobes come from logic on aclk.
// How it works
// - A two-bit clear-channel select field sits at bits 5:4 of the transition control register, reset 3.
// - Clear channel is always set for 0, follows low signal strength for 1, means not receiving for 2, both for 3.
// - A two-bit after-receive field sits at bits 3:2 of the same register, reset 0, used at each end of reception.
// - After reception the radio goes to idle for 0, to synth-on-ready-to-transmit for 1, transmit for 2, stays for 3.
// - A two-bit after-transmit field sits at bits 1:0 of the same register, reset 0, used at each end of sending.
// - After sending the radio goes to idle for 0, receive for 1, synth-on for 2, and restarts preamble for 3.
// - A two-bit auto-calibration field sits at bits 5:4 of the calibration register, reset 0; 0 means manual only.
// - With auto-calibration 1 the synthesizer calibrates on every move from idle into receive, send or synth-on.
// - With auto-calibration 2 it calibrates on every move from receive or send back to idle.
// - With auto-calibration 3 it calibrates on every fourth such return to idle, counted modulo four.
`include "radio_regs.svh"
`default_nettype none

module radio_state_transition_config
    import radio_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CAL_CYCLES = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rssi_below_threshold,
    input wire logic packet_receiving,
    input wire logic rx_packet_done,
    input wire logic tx_packet_done,
    input wire logic enter_rx_strobe,
    input wire logic enter_tx_strobe,
    input wire logic synth_on_tx_ready_strobe,
    input wire logic enter_idle_strobe,
    input wire logic manual_calibrate_strobe,
    output logic clear_channel,
    output logic [2:0] radio_state,
    output logic calibrating,
    output logic preamble_restart
);

    localparam int CNT_W = (CAL_CYCLES > 1) ? $clog2(CAL_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);

    reg_port_if #(.ADDR_W(ADDR_W)) rp ();

    axil_reg_port #(.ADDR_W(ADDR_W)) u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rp(rp)
    );

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        is_mapped = (addr == ADDR_W'(`TRANS_CTRL_ADDR)) || (addr == ADDR_W'(`CAL_CTRL_ADDR))
            || (addr == ADDR_W'(`STATUS_ADDR));
    endfunction : is_mapped

    function automatic logic [2:0] state_code(input radio_state_e st);
        unique case (st)
            ST_IDLE: state_code = `ST_CODE_IDLE;
            ST_RX: state_code = `ST_CODE_RX;
            ST_TX: state_code = `ST_CODE_TX;
            ST_SYNTH_ON: state_code = `ST_CODE_SYNTH_ON;
            ST_CAL: state_code = `ST_CODE_CAL;
        endcase
    endfunction : state_code

    // Register file
    logic [5:0] trans_ctrl_reg, trans_ctrl_next;
    field_t cal_ctrl_reg, cal_ctrl_next;
    field_t clear_channel_select, after_receive_next_state, after_transmit_next_state, synth_auto_calibration;
    logic [1:0] idle_count_reg, idle_count_next;
    logic cca_reg, cca_next;

    assign clear_channel_select = trans_ctrl_reg[`CCA_SEL_LSB +: 2];
    assign after_receive_next_state = trans_ctrl_reg[`RXOFF_LSB +: 2];
    assign after_transmit_next_state = trans_ctrl_reg[`TXOFF_LSB +: 2];
    assign synth_auto_calibration = cal_ctrl_reg;

    always_comb
    begin
        trans_ctrl_next = trans_ctrl_reg;
        cal_ctrl_next = cal_ctrl_reg;
        // Writes land in the register only, so the state machine sees them from the next edge on
        if (rp.wr_en && rp.wr_strb[0])
        begin
            if (rp.wr_addr == ADDR_W'(`TRANS_CTRL_ADDR))
                trans_ctrl_next = rp.wr_data[5:0];
            else if (rp.wr_addr == ADDR_W'(`CAL_CTRL_ADDR))
                cal_ctrl_next = rp.wr_data[`AUTOCAL_LSB +: 2];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trans_ctrl_reg <= `TRANS_CTRL_RESET;
            cal_ctrl_reg <= `CAL_CTRL_RESET;
        end
        else if (clk_en)
        begin
            trans_ctrl_reg <= trans_ctrl_next;
            cal_ctrl_reg <= cal_ctrl_next;
        end
    end

    assign rp.wr_err = !is_mapped(rp.wr_addr);
    assign rp.rd_err = !is_mapped(rp.rd_addr);

    always_comb
    begin
        rp.rd_data = 32'h0;
        // Upper bits stay zero in every register
        if (rp.rd_addr == ADDR_W'(`TRANS_CTRL_ADDR))
            rp.rd_data[5:0] = trans_ctrl_reg;
        else if (rp.rd_addr == ADDR_W'(`CAL_CTRL_ADDR))
            rp.rd_data[`AUTOCAL_LSB +: 2] = cal_ctrl_reg;
        else if (rp.rd_addr == ADDR_W'(`STATUS_ADDR))
        begin
            rp.rd_data[`STAT_STATE_LSB +: 3] = radio_state;
            rp.rd_data[`STAT_CCA_BIT] = cca_reg;
            rp.rd_data[`STAT_IDLECNT_LSB +: 2] = idle_count_reg;
        end
    end

    // Clear channel assessment
    always_comb
    begin
        unique case (clear_channel_select)
            `CCA_ALWAYS: cca_next = 1'b1;
            `CCA_RSSI: cca_next = rssi_below_threshold;
            `CCA_NOT_RX: cca_next = !packet_receiving;
            `CCA_RSSI_NOT_RX: cca_next = rssi_below_threshold && !packet_receiving;
        endcase
    end

    // Main state machine
    radio_state_e state_reg, state_next, ret_reg, ret_next;
    logic [CNT_W-1:0] cal_cnt_reg, cal_cnt_next;
    logic preamble_reg, preamble_next;
    radio_state_e dest;
    logic cal_now;
    logic to_idle;

    always_comb
    begin
        dest = state_reg;
        cal_now = 1'b0;
        to_idle = 1'b0;
        ret_next = ret_reg;
        cal_cnt_next = cal_cnt_reg;
        idle_count_next = idle_count_reg;
        preamble_next = 1'b0;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (manual_calibrate_strobe)
                begin
                    cal_now = 1'b1;
                end
                else if (enter_rx_strobe)
                    dest = ST_RX;
                else if (enter_tx_strobe)
                    dest = ST_TX;
                else if (synth_on_tx_ready_strobe)
                    dest = ST_SYNTH_ON;
                if (dest != ST_IDLE && synth_auto_calibration == `AUTOCAL_FROM_IDLE)
                    cal_now = 1'b1;
            end
            ST_RX:
            begin
                if (enter_idle_strobe)
                    to_idle = 1'b1;
                else if (rx_packet_done)
                begin
                    // Transmit choices here bypass clear-channel checks; software keeps them apart
                    unique case (after_receive_next_state)
                        `RXOFF_IDLE: to_idle = 1'b1;
                        `RXOFF_SYNTH_ON: dest = ST_SYNTH_ON;
                        `RXOFF_TX: dest = ST_TX;
                        `RXOFF_STAY: dest = ST_RX;
                    endcase
                end
            end
            ST_TX:
            begin
                if (enter_idle_strobe)
                    to_idle = 1'b1;
                else if (tx_packet_done)
                begin
                    unique case (after_transmit_next_state)
                        `TXOFF_IDLE: to_idle = 1'b1;
                        `TXOFF_RX: dest = ST_RX;
                        `TXOFF_SYNTH_ON: dest = ST_SYNTH_ON;
                        `TXOFF_STAY: preamble_next = 1'b1;
                    endcase
                end
            end
            ST_SYNTH_ON:
            begin
                if (enter_idle_strobe)
                    dest = ST_IDLE;
                else if (enter_tx_strobe)
                    dest = ST_TX;
            end
            ST_CAL:
            begin
                // Calibration time is a fixed count; the synthesizer gives no done flag here
                if (cal_cnt_reg == '0)
                    dest = ret_reg;
                else
                    cal_cnt_next = cal_cnt_reg - CNT_W'(1'b1);
            end
        endcase
        if (to_idle)
        begin
            dest = ST_IDLE;
            idle_count_next = idle_count_reg + 2'h1;
            if (synth_auto_calibration == `AUTOCAL_TO_IDLE)
                cal_now = 1'b1;
            else if (synth_auto_calibration == `AUTOCAL_FOURTH && idle_count_reg == `IDLE_COUNT_LAST)
                cal_now = 1'b1;
        end
        if (cal_now)
        begin
            state_next = ST_CAL;
            ret_next = dest;
            cal_cnt_next = CAL_LAST;
        end
        else
        begin
            state_next = dest;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= ST_IDLE;
            ret_reg <= ST_IDLE;
            cal_cnt_reg <= '0;
            idle_count_reg <= 2'h0;
            preamble_reg <= 1'b0;
            cca_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            ret_reg <= ret_next;
            cal_cnt_reg <= cal_cnt_next;
            idle_count_reg <= idle_count_next;
            preamble_reg <= preamble_next;
            cca_reg <= cca_next;
        end
    end

    assign clear_channel = cca_reg;
    assign radio_state = state_code(state_reg);
    assign calibrating = (state_reg == ST_CAL);
    assign preamble_restart = preamble_reg;

endmodule : radio_state_transition_config

`default_nettype wire

// ===== hw/reg_port_if.sv
// Register access strobes between the AXI4-Lite slave and the register file.
// Assumes both ends run on the same clock.
`default_nettype none

interface reg_port_if #(parameter int ADDR_W = 8);
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;

    modport port (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_err, rd_data, rd_err);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_err, rd_data, rd_err);
endinterface : reg_port_if

`default_nettype wire
